// ### cmt_defs.svh
// register offsets, reset values and cycle counts of the core timing block
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH
`define CMT_SP_ADDR      8'h81
`define CMT_SPH_ADDR     8'hB7
`define CMT_EWS_ADDR     8'h9F
`define CMT_SP_RST       8'h07
`define CMT_SPH_RST      3'h0
`define CMT_EWS_RST      8'h00
`define CMT_BIT_BASE     8'h20
`define CMT_BANK_W       2
`define CMT_CODE_TOP     16'hF7FF
`define CMT_FLASH_RW_TOP 16'hDFFF
`define CMT_CYC_1        9'h001
`define CMT_CYC_2        9'h002
`define CMT_CYC_3        9'h003
`define CMT_CYC_4        9'h004
`define CMT_CYC_IRQ      9'h003
`define CMT_CYC_DEF      9'h001
`endif

// ### cmt_pkg.sv
// types shared by the core timing block
package cmt_pkg;
  // access sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_BWR  = 3'b100
  } cmt_state_t;
  // instruction timing classes
  typedef enum logic [2:0] {
    CL_ONE  = 3'h0,
    CL_TWO  = 3'h1,
    CL_THR  = 3'h2,
    CL_FOUR = 3'h3,
    CL_XDM  = 3'h4,
    CL_DEF  = 3'h5
  } cmt_class_t;
  // which requester a pending read belongs to
  typedef enum logic [1:0] {
    RK_MEM = 2'h0,
    RK_STK = 2'h1,
    RK_BIT = 2'h2
  } cmt_rdkind_t;
endpackage

// ### cmt_ram.sv
// single-port byte memory with registered read data
`timescale 1ns/1ps
module cmt_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk_i,
  input  wire logic          en_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [DEPTH];  // storage, no reset by design

  // refuse an address range that cannot cover the depth
  if ((1 << AW) < DEPTH) begin : g_chk
    $error("cmt_ram: AW too small for DEPTH");
  end

  // read first, read returns old contents
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule

// ### cmt_cycle_ctr.sv
// down counter that holds an instruction for its machine cycles
`timescale 1ns/1ps
module cmt_cycle_ctr #(
  parameter int W = 9
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              busy_o,
  output logic              done_o
);
  logic [W-1:0] cnt_q;  // cycles still to run, current one included

  // one step per core clock; done marks the last cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_q  <= count_i;
      busy_o <= 1'b1;
      done_o <= (count_i == W'(1));
    end else begin
      cnt_q  <= (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
      busy_o <= (cnt_q > W'(1));
      done_o <= (cnt_q == W'(2));
    end
  end
endmodule

// ### cmt_core_timing.sv
// instruction timing, internal RAM map, stack and code space checks of the core
// Behaviour
// - every cycle is one core clock
// - one-byte accumulator and carry ops take one
// - register-indirect moves and exchanges take two
// - two-byte direct ops, push, pop take two
// - direct-to-direct copy and pointer load take three
// - code byte reads take four cycles
// - external moves take four plus wait states
// - both returns take four cycles
// - two-byte branches and indirect jump take three
// - three-byte branches take four cycles
// - interrupt entry long call takes three
// - upper RAM half only indirect; direct hits registers
// - lowest 32 bytes are four register banks
// - bytes 20H-2FH hold bit addresses 00H-7FH
// - stack pointer resets to 07H
// - push and call pre-increment the stack pointer
// - stack anywhere, up to 2048 bytes deep
// - registers at x0H or x8H are bit addressable for reads; their bit writes are dropped
// - code fetched only from internal 62 kbytes
// - 2 kbytes extended RAM beside internal RAM
// - 56 kbytes of program flash writable at run
`timescale 1ns/1ps
`include "cmt_defs.svh"
module cmt_core_timing #(
  parameter int EXTENDED_DATA_RAM_DEPTH = 2048,
  parameter int SP_W       = 11
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        NRST_I,
  input  wire logic        EXTERNAL_ACCESS_INPUT_I,
  input  wire logic        OP_VALID_I,
  input  wire logic [7:0]  OPCODE_I,
  input  wire logic        IRQ_ENTRY_I,
  output logic             OP_BUSY_O,
  output logic             OP_DONE_O,
  output logic [8:0]       OP_CYCLES_O,
  input  wire logic        STK_PUSH_I,
  input  wire logic        STK_POP_I,
  input  wire logic [7:0]  STK_WDATA_I,
  output logic [7:0]       STK_RDATA_O,
  output logic             STK_RVALID_O,
  output logic [10:0]      SP_O,
  input  wire logic        MEM_REQ_I,
  input  wire logic        MEM_WR_I,
  input  wire logic        MEM_IND_I,
  input  wire logic        MEM_REG_I,
  input  wire logic [1:0]  BANK_SEL_I,
  input  wire logic [7:0]  MEM_ADDR_I,
  input  wire logic [7:0]  MEM_WDATA_I,
  output logic [7:0]       MEM_RDATA_O,
  output logic             MEM_RVALID_O,
  input  wire logic        BIT_REQ_I,
  input  wire logic        BIT_WR_I,
  input  wire logic [7:0]  BIT_ADDR_I,
  input  wire logic        BIT_VAL_I,
  output logic             BIT_RDATA_O,
  output logic             BIT_RVALID_O,
  output logic [7:0]       BIT_BYTE_O,
  output logic             ACC_READY_O,
  input  wire logic        FETCH_REQ_I,
  input  wire logic [15:0] FETCH_ADDR_I,
  output logic             FETCH_OK_O,
  input  wire logic        FLASH_WR_REQ_I,
  input  wire logic [15:0] FLASH_WR_ADDR_I,
  output logic             FLASH_WR_OK_O
);
  // the stack must reach 2048 bytes of extended RAM
  if (EXTENDED_DATA_RAM_DEPTH < 2048 || SP_W != 11) begin : g_chk
    $error("cmt_core_timing: stack needs 2048 bytes and an 11-bit pointer");
  end

  // timing class of an opcode
  function automatic cmt_pkg::cmt_class_t op_class(input logic [7:0] op);
    cmt_pkg::cmt_class_t c;
    c = cmt_pkg::CL_DEF;
    casez (op)
      8'h00, 8'h03, 8'h13, 8'h23, 8'h33, 8'hC3, 8'hD3, 8'hB3,
      8'b1110_1???, 8'b1111_1???, 8'b1100_1???: c = cmt_pkg::CL_ONE;
      8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7, 8'hD6, 8'hD7,
      8'h76, 8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7: c = cmt_pkg::CL_TWO;
      8'hE5, 8'h74, 8'hF5, 8'h75, 8'hC0, 8'hD0, 8'hC5, 8'hC2, 8'hD2, 8'hB2,
      8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92,
      8'b0111_1???, 8'b1010_1???, 8'b1000_1???: c = cmt_pkg::CL_TWO;
      8'h85, 8'h90: c = cmt_pkg::CL_THR;
      8'h93, 8'h83: c = cmt_pkg::CL_FOUR;
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: c = cmt_pkg::CL_XDM;
      8'h22, 8'h32: c = cmt_pkg::CL_FOUR;
      8'h73, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70,
      8'b1101_1???, 8'b???0_0001, 8'b???1_0001: c = cmt_pkg::CL_THR;
      8'h02, 8'h12, 8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'hB6, 8'hB7,
      8'b1011_1???, 8'hD5: c = cmt_pkg::CL_FOUR;
      default: c = cmt_pkg::CL_DEF;
    endcase
    return c;
  endfunction

  // byte that holds a bit address: RAM area or a bit-addressable register
  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    return ba[7] ? {ba[7:3], 3'h0}
                 : `CMT_BIT_BASE | {4'h0, ba[6:3]};
  endfunction

  // ---------------- instruction timing ----------------
  cmt_pkg::cmt_class_t cls;          // class of the offered opcode
  logic [8:0]          cyc;          // cycles the offered op will take
  logic [7:0]          ews_q;        // external wait states
  logic                ctr_busy;     // counter still running
  logic                ctr_done;     // last cycle of the running op
  logic                op_go;        // op taken this edge

  assign cls   = op_class(OPCODE_I);
  assign op_go = OP_VALID_I && (!ctr_busy || ctr_done);

  // cycle count per class; interrupt entry shortens the long call
  always_comb begin
    case (cls)
      cmt_pkg::CL_ONE:  cyc = `CMT_CYC_1;
      cmt_pkg::CL_TWO:  cyc = `CMT_CYC_2;
      cmt_pkg::CL_THR:  cyc = `CMT_CYC_3;
      cmt_pkg::CL_FOUR: cyc = `CMT_CYC_4;
      cmt_pkg::CL_XDM:  cyc = `CMT_CYC_4 + {1'b0, ews_q};
      default:          cyc = `CMT_CYC_DEF;
    endcase
    if (IRQ_ENTRY_I) begin
      cyc = `CMT_CYC_IRQ;
    end
  end

  // one count per core clock
  cmt_cycle_ctr #(.W(9)) u_ctr (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (NRST_I),
    .load_i  (op_go),
    .count_i (cyc),
    .busy_o  (ctr_busy),
    .done_o  (ctr_done)
  );
  assign OP_BUSY_O = ctr_busy;
  assign OP_DONE_O = ctr_done;

  // remember the length of the op taken
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      OP_CYCLES_O <= '0;
    end else if (op_go) begin
      OP_CYCLES_O <= cyc;
    end
  end

  // ---------------- data access sequencer ----------------
  cmt_pkg::cmt_state_t  state_q, state_d;  // sequencer state
  cmt_pkg::cmt_rdkind_t kind_q;            // owner of pending read
  logic [10:0] sp_q;        // stack pointer, high bits from extension
  logic        idle, bwr;   // state decodes
  logic        push_go, pop_go, bit_go, mem_go;
  logic [10:0] sp_inc, stk_addr;
  logic        stk_iram;    // stack byte lies in internal RAM
  logic [7:0]  m_addr;      // resolved byte address of a byte access
  logic        m_sfr;       // direct high address: register space
  logic        sfr_wr;      // register write this edge
  logic [7:0]  bb;          // byte of the requested bit
  logic        src_sfr_q, src_x_q;
  logic [7:0]  hold_q;      // register value caught at request
  logic [2:0]  bsel_q;      // bit position
  logic        bwr_q, bval_q, bsfr_q;
  logic [7:0]  bbyte_q;     // byte of a pending bit op
  logic [7:0]  data_q;      // byte read for a bit write-back
  logic [7:0]  rd_byte;     // byte returned by the pending read
  logic [7:0]  wb_byte;     // byte with the bit replaced
  logic        iram_en, iram_we, x_en, x_we;
  logic [7:0]  iram_addr, iram_wd, iram_rd, x_rd;

  // register read decode, shared by byte and bit reads
  function automatic logic [7:0] sfr_rd(input logic [7:0] a, input logic [10:0] sp,
                                        input logic [7:0] ews);
    case (a)
      `CMT_SP_ADDR:  return sp[7:0];
      `CMT_SPH_ADDR: return {5'h0, sp[10:8]};
      `CMT_EWS_ADDR: return ews;
      default:       return 8'h00;
    endcase
  endfunction

  assign idle     = (state_q == cmt_pkg::ST_IDLE);
  assign bwr      = (state_q == cmt_pkg::ST_BWR);
  // stack first, then bit ops, then byte accesses
  assign push_go  = idle && STK_PUSH_I;
  assign pop_go   = idle && STK_POP_I && !STK_PUSH_I;
  assign bit_go   = idle && BIT_REQ_I && !STK_PUSH_I && !STK_POP_I;
  assign mem_go   = idle && MEM_REQ_I && !BIT_REQ_I && !STK_PUSH_I && !STK_POP_I;
  assign sp_inc   = sp_q + 11'h001;
  assign stk_addr = push_go ? sp_inc : sp_q;
  assign stk_iram = (stk_addr[10:8] == 3'h0);
  assign m_addr   = MEM_REG_I ? {3'h0, BANK_SEL_I, MEM_ADDR_I[2:0]} : MEM_ADDR_I;
  assign m_sfr    = !MEM_IND_I && !MEM_REG_I && MEM_ADDR_I[7];
  assign sfr_wr   = mem_go && MEM_WR_I && m_sfr;
  assign bb       = bit_byte(BIT_ADDR_I);
  assign rd_byte  = src_sfr_q ? hold_q : (src_x_q ? x_rd : iram_rd);
  assign wb_byte  = (data_q & ~(8'h01 << bsel_q)) | ({7'h0, bval_q} << bsel_q);

  // internal RAM port: indirect reaches all 256 bytes
  assign iram_en   = ((push_go || pop_go) && stk_iram) || (bit_go && !BIT_ADDR_I[7])
                   || (mem_go && !m_sfr) || bwr;
  assign iram_we   = (push_go && stk_iram) || (mem_go && MEM_WR_I && !m_sfr) || bwr;
  assign iram_addr = (push_go || pop_go) ? stk_addr[7:0] : (bit_go ? bb : (bwr ? bbyte_q : m_addr));
  assign iram_wd   = push_go ? STK_WDATA_I : (bwr ? wb_byte : MEM_WDATA_I);
  // stack beyond the first 256 bytes spills into extended RAM
  assign x_en      = (push_go || pop_go) && !stk_iram;
  assign x_we      = push_go && !stk_iram;

  cmt_ram #(.DEPTH(256), .AW(8)) u_iram (
    .clk_i   (CLK_SYS_I),
    .en_i    (iram_en),
    .we_i    (iram_we),
    .addr_i  (iram_addr),
    .wdata_i (iram_wd),
    .rdata_o (iram_rd)
  );
  cmt_ram #(.DEPTH(EXTENDED_DATA_RAM_DEPTH), .AW(11)) u_extended_data_ram (
    .clk_i   (CLK_SYS_I),
    .en_i    (x_en),
    .we_i    (x_we),
    .addr_i  (stk_addr),
    .wdata_i (STK_WDATA_I),
    .rdata_o (x_rd)
  );

  // next state: reads wait one cycle, RAM bit writes add a write-back
  always_comb begin
    state_d = state_q;
    case (state_q)
      cmt_pkg::ST_IDLE: begin
        if (pop_go || bit_go || (mem_go && !MEM_WR_I)) begin
          state_d = cmt_pkg::ST_RD;
        end
      end
      cmt_pkg::ST_RD: begin
        state_d = (kind_q == cmt_pkg::RK_BIT && bwr_q && !bsfr_q) ? cmt_pkg::ST_BWR : cmt_pkg::ST_IDLE;
      end
      cmt_pkg::ST_BWR: state_d = cmt_pkg::ST_IDLE;
      default:         state_d = cmt_pkg::ST_IDLE;
    endcase
  end

  // sequencer state and ready flag
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q     <= cmt_pkg::ST_IDLE;
      ACC_READY_O <= 1'b1;
    end else begin
      state_q     <= state_d;
      ACC_READY_O <= (state_d == cmt_pkg::ST_IDLE);
    end
  end

  // stack pointer, its extension and the wait-state register
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sp_q  <= {`CMT_SPH_RST, `CMT_SP_RST};
      ews_q <= `CMT_EWS_RST;
    end else begin
      if (push_go) begin
        sp_q <= sp_inc;
      end else if (pop_go) begin
        sp_q <= sp_q - 11'h001;
      end else if (sfr_wr && MEM_ADDR_I == `CMT_SP_ADDR) begin
        sp_q[7:0] <= MEM_WDATA_I;
      end else if (sfr_wr && MEM_ADDR_I == `CMT_SPH_ADDR) begin
        sp_q[10:8] <= MEM_WDATA_I[2:0];
      end
      if (sfr_wr && MEM_ADDR_I == `CMT_EWS_ADDR) begin
        ews_q <= MEM_WDATA_I;
      end
    end
  end
  assign SP_O = sp_q;

  // capture what a pending read needs; register bits read from hold
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      kind_q    <= cmt_pkg::RK_MEM;
      src_sfr_q <= 1'b0;
      src_x_q   <= 1'b0;
      hold_q    <= 8'h00;
      bsel_q    <= 3'h0;
      bwr_q     <= 1'b0;
      bval_q    <= 1'b0;
      bsfr_q    <= 1'b0;
      bbyte_q   <= 8'h00;
    end else if (idle) begin
      kind_q    <= pop_go ? cmt_pkg::RK_STK : (bit_go ? cmt_pkg::RK_BIT : cmt_pkg::RK_MEM);
      src_sfr_q <= bit_go ? BIT_ADDR_I[7] : (!pop_go && m_sfr);
      src_x_q   <= pop_go && !stk_iram;
      hold_q    <= sfr_rd(bit_go ? bb : MEM_ADDR_I, sp_q, ews_q);
      bsel_q    <= BIT_ADDR_I[2:0];
      bwr_q     <= BIT_WR_I;
      bval_q    <= BIT_VAL_I;
      bsfr_q    <= BIT_ADDR_I[7];  // all register bit writes are dropped
      bbyte_q   <= bb;
    end
  end

  // answers: byte data, bit value and one-cycle valids
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      data_q       <= 8'h00;
      MEM_RDATA_O  <= 8'h00;
      STK_RDATA_O  <= 8'h00;
      BIT_RDATA_O  <= 1'b0;
      MEM_RVALID_O <= 1'b0;
      STK_RVALID_O <= 1'b0;
      BIT_RVALID_O <= 1'b0;
      BIT_BYTE_O   <= 8'h00;
    end else begin
      MEM_RVALID_O <= (state_q == cmt_pkg::ST_RD) && (kind_q == cmt_pkg::RK_MEM);
      STK_RVALID_O <= (state_q == cmt_pkg::ST_RD) && (kind_q == cmt_pkg::RK_STK);
      BIT_RVALID_O <= (state_q == cmt_pkg::ST_RD) && (kind_q == cmt_pkg::RK_BIT);
      if (state_q == cmt_pkg::ST_RD) begin
        data_q      <= rd_byte;
        MEM_RDATA_O <= rd_byte;
        STK_RDATA_O <= rd_byte;
        BIT_RDATA_O <= rd_byte[bsel_q];
      end
      if (bit_go) begin
        BIT_BYTE_O <= bb;
      end
    end
  end

  // ---------------- code space ----------------
  logic strap_done_q;  // strap sampled once after reset release
  logic ea_q;          // internal execution selected

  // strap caught by the first clocked edge after release
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      strap_done_q <= 1'b0;
      ea_q         <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      ea_q         <= EXTERNAL_ACCESS_INPUT_I;
    end
  end

  // no rollover into external code; only the low 56 kbytes are writable
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FETCH_OK_O    <= 1'b0;
      FLASH_WR_OK_O <= 1'b0;
    end else begin
      FETCH_OK_O    <= FETCH_REQ_I && ea_q && (FETCH_ADDR_I <= `CMT_CODE_TOP);
      FLASH_WR_OK_O <= FLASH_WR_REQ_I && (FLASH_WR_ADDR_I <= `CMT_FLASH_RW_TOP);
    end
  end

  // ---------------- checks ----------------
  sequence s_wait3_done;
    !OP_DONE_O [*3] ##1 OP_DONE_O;
  endsequence
  sequence s_wait2_done;
    !OP_DONE_O [*2] ##1 OP_DONE_O;
  endsequence

  sp_reset_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    $rose(NRST_I) |-> sp_q == 11'h007) else $error("stack pointer not 07H after reset");
  push_inc_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    push_go |=> sp_q == $past(sp_q) + 11'h001) else $error("push did not pre-increment");
  pop_dec_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    pop_go |=> sp_q == $past(sp_q) - 11'h001) else $error("pop did not decrement");
  one_cycle_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (op_go && !IRQ_ENTRY_I && OPCODE_I == 8'h00) |=> OP_DONE_O) else $error("nop not one cycle");
  ext_move_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (op_go && !IRQ_ENTRY_I && OPCODE_I == 8'hE0 && ews_q == 8'h00) |=> s_wait3_done)
    else $error("external move not four cycles");
  ret_len_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (op_go && !IRQ_ENTRY_I && OPCODE_I == 8'h32) |=> s_wait3_done) else $error("return not four cycles");
  irq_call_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (op_go && IRQ_ENTRY_I) |=> s_wait2_done) else $error("interrupt call not three cycles");
  bit_map_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (bit_go && !BIT_ADDR_I[7]) |=> BIT_BYTE_O == 8'h20 + {4'h0, $past(BIT_ADDR_I[6:3])})
    else $error("bit address mapped to wrong byte");
  fetch_lim_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (FETCH_REQ_I && FETCH_ADDR_I > 16'hF7FF) |=> !FETCH_OK_O) else $error("fetch beyond internal code");
  dir_sfr_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (mem_go && m_sfr) |-> !iram_en) else $error("direct high address reached RAM");
endmodule

// ### cmt_flash_model.sv
// far-side stand-in issuing code fetch and flash write requests
`timescale 1ns/1ps
module cmt_flash_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  output logic             fetch_req_o,
  output logic             wr_req_o,
  output logic [15:0]      addr_o
);
  // one-cycle request launched after an edge
  // idle address is scrambled so a stale value cannot pass for a live one
  always @(posedge clk_i) begin
    fetch_req_o <= go_i & ~wr_i;
    wr_req_o    <= go_i & wr_i;
    addr_o      <= go_i ? addr_i : ~addr_o;
  end
  // quiet at time zero
  initial begin
    fetch_req_o = 1'b0;
    wr_req_o    = 1'b0;
    addr_o      = 16'h0000;
  end
endmodule

// ### tb.sv
// self-checking bench for the core timing block
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst_n = 0, ea = 1, opv = 0, irq = 0, push = 0, pop = 0, go = 0, gwr = 0;
  logic mreq = 0, mwr = 0, mind = 0, mreg = 0, breq = 0, bwr = 0, bval = 0, fq = 0, fw = 0;
  logic [7:0] opc = 0, swd = 0, maddr = 0, mwd = 0, baddr = 0, bbyte, mrd, srd, r, d0, d1;
  logic [1:0] bank = 0;
  logic [15:0] gaddr = 0, faddr;
  logic [8:0] cyc;
  logic [10:0] sp, tq, q_cyc[$], q_mem[$], q_stk[$], q_bit[$], q_fch[$];
  logic busy, done, srv, mrv, brd, brv, rdy, fok, wok, freq, wreq;
  int bad_count = 0, checks_done = 0, n = 0;
  // opcode and expected cycles packed as {op, cycles}
  localparam logic [15:0] OT [28] = '{16'h0001, 16'h1301, 16'hC301, 16'hD301, 16'hB301, 16'hE801,
    16'hC801, 16'hE602, 16'hC002, 16'hD002, 16'h8503, 16'h9003, 16'h7303, 16'h8003, 16'h4003,
    16'hD803, 16'h0103, 16'h1103, 16'h9304, 16'h8304, 16'h2204, 16'h3204, 16'h0204, 16'h1204,
    16'h2004, 16'h1004, 16'hB404, 16'hD504};

  always #20 clk = ~clk;

  cmt_core_timing dut_u (
    .CLK_SYS_I(clk), .NRST_I(rst_n), .EXTERNAL_ACCESS_INPUT_I(ea), .OP_VALID_I(opv), .OPCODE_I(opc),
    .IRQ_ENTRY_I(irq), .OP_BUSY_O(busy), .OP_DONE_O(done), .OP_CYCLES_O(cyc), .STK_PUSH_I(push),
    .STK_POP_I(pop), .STK_WDATA_I(swd), .STK_RDATA_O(srd), .STK_RVALID_O(srv), .SP_O(sp),
    .MEM_REQ_I(mreq), .MEM_WR_I(mwr), .MEM_IND_I(mind), .MEM_REG_I(mreg), .BANK_SEL_I(bank),
    .MEM_ADDR_I(maddr), .MEM_WDATA_I(mwd), .MEM_RDATA_O(mrd), .MEM_RVALID_O(mrv), .BIT_REQ_I(breq),
    .BIT_WR_I(bwr), .BIT_ADDR_I(baddr), .BIT_VAL_I(bval), .BIT_RDATA_O(brd), .BIT_RVALID_O(brv),
    .BIT_BYTE_O(bbyte), .ACC_READY_O(rdy), .FETCH_REQ_I(freq), .FETCH_ADDR_I(faddr),
    .FETCH_OK_O(fok), .FLASH_WR_REQ_I(wreq), .FLASH_WR_ADDR_I(faddr), .FLASH_WR_OK_O(wok));

  cmt_flash_model flash_u (.clk_i(clk), .go_i(go), .wr_i(gwr), .addr_i(gaddr),
    .fetch_req_o(freq), .wr_req_o(wreq), .addr_o(faddr));

  // one compare for every kind of result
  task automatic chk(input string s, input logic [10:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // wait until the access port is idle, then sit on a launch edge
  task automatic arm();
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  // hold the request over the taking edge, then release
  task automatic drop();
    @(posedge clk);
    push <= 0; pop <= 0; breq <= 0; mreq <= 0;
  endtask

  // byte access: write, direct, indirect or bank register
  task automatic mem(input logic w, ind, rg, input logic [7:0] a, d, e);
    arm();
    mreq <= 1; mwr <= w; mind <= ind; mreg <= rg; maddr <= a; mwd <= d;
    if (!w) q_mem.push_back({3'b0, e});
    drop();
  endtask

  // push when pu is high, otherwise pop
  task automatic stk(input logic pu, input logic [7:0] d, e);
    arm();
    push <= pu; pop <= !pu; swd <= d;
    if (!pu) q_stk.push_back({3'b0, e});
    drop();
  endtask

  // bit access, answer carries old bit and resolved byte
  task automatic bop(input logic w, v, input logic [7:0] a, input logic e, input logic [7:0] eb);
    arm();
    breq <= 1; bwr <= w; bval <= v; baddr <= a;
    q_bit.push_back({2'b0, e, eb});
    drop();
  endtask

  // offer one opcode once the previous one is finished
  task automatic op(input logic [7:0] c, input logic i, input logic [8:0] e);
    @(negedge clk);
    while (busy === 1'b1) @(negedge clk);
    @(posedge clk);
    opv <= 1; opc <= c; irq <= i;
    q_cyc.push_back({2'b0, e});
    @(posedge clk);
    opv <= 0;
  endtask

  // one fetch or flash write request through the far-side model
  task automatic fl(input logic w, input logic [15:0] a, input logic e);
    @(posedge clk);
    go <= 1; gwr <= w; gaddr <= a;
    q_fch.push_back({10'b0, e});
    @(posedge clk);
    go <= 0;
  endtask

  // result watcher: oldest note against each answer
  always @(posedge clk) begin
    if (!rst_n) n = 0;
    else begin
      if (busy === 1'b1) n++;
      if (done === 1'b1) begin
        chk("busy_cycles", q_cyc[0], 11'(n));
        chk("op_cycles", q_cyc.pop_front(), {2'b0, cyc});
        n = 0;
      end
      if (mrv === 1'b1) chk("mem_rdata", q_mem.pop_front(), {3'b0, mrd});
      if (mrv === 1'b1) chk("acc_ready", 11'h001, {10'b0, rdy});
      if (srv === 1'b1) chk("pop_data", q_stk.pop_front(), {3'b0, srd});
      if (brv === 1'b1) begin
        tq = q_bit.pop_front();
        chk("bit_old", {10'b0, tq[8]}, {10'b0, brd});
        chk("bit_byte", {3'b0, tq[7:0]}, {3'b0, bbyte});
      end
    end
    if (fq) chk("flash_ok", q_fch.pop_front(), {10'b0, fw ? wok : fok});
    fq <= freq | wreq;
    fw <= wreq;
  end

  // hang guard, well beyond the expected few hundred cycles
  initial begin
    #400000;
    bad_count++;
    results();
  end

  initial begin
    void'($urandom(32'hB6B48E14));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    chk("sp_reset", 11'h007, sp);
    // every timing class but the default, then interrupt entry and wait states
    foreach (OT[i]) op(OT[i][15:8], 1'b0, {5'b0, OT[i][3:0]});
    op(8'h12, 1'b1, 9'h003);
    r = 8'($urandom_range(7));
    mem(1, 0, 0, 8'h9F, r, 0);
    op(8'hE0, 1'b0, 9'h004 + r);
    op(8'hF0, 1'b0, 9'h004 + r);
    mem(0, 0, 0, 8'h9F, 0, r);
    $display("test op timing done");
    // stack pre-increment, banks, extension into extended RAM
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    stk(1, d0, 0);
    stk(1, d1, 0);
    mem(0, 0, 0, 8'h81, 0, 8'h09);
    bank <= 2'h1;
    mem(0, 0, 1, 8'h00, 0, d0);
    mem(0, 0, 1, 8'h01, 0, d1);
    stk(0, 0, d1);
    stk(0, 0, d0);
    mem(0, 0, 0, 8'h81, 0, 8'h07);
    mem(1, 0, 0, 8'h81, 8'hFF, 0);
    stk(1, r ^ 8'h5A, 0);
    mem(0, 0, 0, 8'hB7, 0, 8'h01);
    mem(0, 0, 0, 8'h81, 0, 8'h00);
    stk(0, 0, r ^ 8'h5A);
    $display("test stack done");
    // upper half indirect only, lower half both ways
    mem(1, 1, 0, 8'h90, d1, 0);
    mem(0, 0, 0, 8'h90, 0, 8'h00);
    mem(0, 1, 0, 8'h90, 0, d1);
    mem(1, 0, 0, 8'h40, d0, 0);
    mem(0, 1, 0, 8'h40, 0, d0);
    $display("test ram halves done");
    // bit area and register-space bits
    mem(1, 0, 0, 8'h21, 8'h00, 0);
    mem(1, 0, 0, 8'h2F, 8'h80, 0);
    bop(1, 1, 8'h09, 0, 8'h21);
    mem(0, 0, 0, 8'h21, 0, 8'h02);
    bop(0, 0, 8'h7F, 1, 8'h2F);
    bop(0, 0, 8'h83, 0, 8'h80);
    $display("test bits done");
    // code space and writable flash limits
    fl(0, 16'hF7FF, 1);
    fl(0, 16'hF800, 0);
    fl(1, 16'hDFFF, 1);
    fl(1, 16'hE000, 0);
    // second reset with the strap low: no code fetch at all
    @(posedge clk);
    rst_n <= 0;
    ea <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    fl(0, 16'h0000, 0);
    mem(0, 0, 0, 8'h81, 0, 8'h07);
    $display("test code space done");
    repeat (6) @(posedge clk);
    results();
  end
endmodule
